// ### core/flash_status_defines.svh
// Constants for the status register command logic of the serial flash.
`ifndef FLASH_STATUS_DEFINES_SVH
`define FLASH_STATUS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define FS_OP_ACTIVE_STATUS   8'h25
`define FS_OP_WRITE_STATUS1   8'h01
`define FS_OP_WRITE_STATUS2   8'h31

// ----------------------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------------------
`define FS_SR_BUSY_BIT        0
`define FS_SR1_WEL_BIT        1
`define FS_SR1_LOCK_BIT       7
`define FS_SR2_RESET_COMMAND_ENABLE_BIT       4
`define FS_STATUS_ZERO        8'h00

// ----------------------------------------------------------------------------
// Write data fields
// ----------------------------------------------------------------------------
`define FS_WD_LOCK_BIT        7
`define FS_WD_GP_MSB          5
`define FS_WD_GP_LSB          2
`define FS_WD_RESET_COMMAND_ENABLE_BIT        4

// ----------------------------------------------------------------------------
// Frame counting and reset values
// ----------------------------------------------------------------------------
`define FS_BIT_FIRST          3'h0
`define FS_BIT_LAST           3'h7
`define FS_BIT_STEP           3'h1
`define FS_BYTES_NONE         2'h0
`define FS_BYTES_OPCODE       2'h1
`define FS_BYTES_FULL         2'h2
`define FS_BYTE_STEP          2'h1
`define FS_RESET_COMMAND_ENABLE_RESET         1'h0
`define FS_LOCK_RESET         1'h0
`define FS_WEL_RESET          1'h0

`endif

// ### core/flash_status_pkg.sv
// Types shared by the status register command logic.
package flash_status_pkg;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_ACTIVE_STATUS,
    CMD_WRITE_STATUS1,
    CMD_WRITE_STATUS2,
    CMD_READ_STATUS1,
    CMD_READ_STATUS2
  } cmd_e;

  typedef enum logic [1:0] {
    LS_IDLE,
    LS_CMD,
    LS_ACTIVE
  } link_state_e;

endpackage : flash_status_pkg

// ### core/bit_sync.sv
// Two flip-flop synchroniser for independent level signals.
`timescale 1ns/1ns
module bit_sync #(
  parameter int                 WIDTH       = 1,
  parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // Each bit is synchronised on its own; only use it for bits that carry
  // no meaning as a group.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= RESET_VALUE;
      q        <= RESET_VALUE;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : bit_sync

// ### core/flash_status_register_commands.sv
// Status register commands of a serial flash: busy polling, active status, status writes.
//
// Notes on behaviour
// - Busy flag high during program or erase.
// - Same busy flag in both status bytes.
// - Reset-enable powers up 0, gates reset commands.
// - Reset-enable changes only by second-byte write.
// - Byte two: bit4 reset-enable, bit0 busy, rest zero.
// - Active status drives live busy on output.
// - Chip select release ends it, output released.
// - Busy flag readable at any time.
// - First write: bit7 lock, bits5-2 protect code.
// - On release update lock, clear latch, request protect.
// - Short first write aborts, latch still cleared.
// - Protect pin blocks clearing lock, latch cleared.
// - Second write takes bit4, clears latch on release.
// - Short or unaligned second write aborts, latch cleared.
// - Latch low refuses status writes.
`include "flash_status_defines.svh"
`timescale 1ns/1ns
module flash_status_register_commands #(
  parameter logic [7:0] READ_STATUS1_OPCODE = 8'h05,
  parameter logic [7:0] READ_STATUS2_OPCODE = 8'h35
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       sck,
  input  wire logic       cs_b,
  input  wire logic       si,
  output logic            so_out,
  output logic            so_oe,
  input  wire logic       wp_b,
  input  wire logic       op_busy,
  input  wire logic       wel_set,
  input  wire logic       wel_clear,
  input  wire logic       reset_cmd_req,
  output logic            reset_accept,
  output logic            write_enable_latch,
  output logic            protection_lock_bit,
  output logic            reset_command_enable,
  output logic            ready_busy_flag,
  output logic [7:0]      status_byte2,
  output logic            global_protect_req,
  output logic [3:0]      global_protect_code,
  output logic            global_protect_prior_lock
);

  // --------------------------------------------------------------------------
  // Decoding
  // --------------------------------------------------------------------------
  function automatic flash_status_pkg::cmd_e decode_opcode(input logic [7:0] op);
    flash_status_pkg::cmd_e c;
    c = flash_status_pkg::CMD_NONE;
    if (op == `FS_OP_ACTIVE_STATUS) c = flash_status_pkg::CMD_ACTIVE_STATUS;
    if (op == `FS_OP_WRITE_STATUS1) c = flash_status_pkg::CMD_WRITE_STATUS1;
    if (op == `FS_OP_WRITE_STATUS2) c = flash_status_pkg::CMD_WRITE_STATUS2;
    if (op == READ_STATUS1_OPCODE)  c = flash_status_pkg::CMD_READ_STATUS1;
    if (op == READ_STATUS2_OPCODE)  c = flash_status_pkg::CMD_READ_STATUS2;
    return c;
  endfunction : decode_opcode

  // --------------------------------------------------------------------------
  // Serial clock domain: frame tracking and shift in
  // --------------------------------------------------------------------------
  // The serial clock only runs inside a frame, so the start of a frame is
  // recognised by a flag that chip select clears without needing an edge.
  logic       frame_reg;
  logic [2:0] bit_cnt_reg;
  logic [1:0] bytes_reg;
  logic [6:0] shift_reg;
  logic [7:0] opcode_reg;
  logic [7:0] data_reg;
  logic       op_tgl_reg;

  wire  [2:0] bit_cur  = frame_reg ? bit_cnt_reg : `FS_BIT_FIRST;
  wire  [1:0] byte_cur = frame_reg ? bytes_reg : `FS_BYTES_NONE;
  wire  [7:0] byte_in  = {shift_reg, si};
  wire        byte_end = (bit_cur == `FS_BIT_LAST);
  wire        op_end   = byte_end && (byte_cur == `FS_BYTES_NONE);
  wire        data_end = byte_end && (byte_cur == `FS_BYTES_OPCODE);
  wire  [1:0] byte_nxt = (byte_end && byte_cur != `FS_BYTES_FULL) ? byte_cur + `FS_BYTE_STEP : byte_cur;

  always_ff @(posedge sck or posedge cs_b or negedge rst_b) begin
    if (!rst_b) begin
      frame_reg <= 1'h0;
    end else if (cs_b) begin
      frame_reg <= 1'h0;
    end else begin
      frame_reg <= 1'h1;
    end
  end

  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_reg <= `FS_BIT_FIRST;
      bytes_reg   <= `FS_BYTES_NONE;
      shift_reg   <= 7'h00;
    end else begin
      bit_cnt_reg <= bit_cur + `FS_BIT_STEP;
      bytes_reg   <= byte_nxt;
      shift_reg   <= byte_in[6:0];
    end
  end

  // Opcode and data stay frozen from their byte end until the next frame
  // reaches the same point, which lets the system side read them as words.
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      opcode_reg <= 8'h00;
      data_reg   <= 8'h00;
      op_tgl_reg <= 1'h0;
    end else begin
      if (op_end) begin
        opcode_reg <= byte_in;
        op_tgl_reg <= ~op_tgl_reg;
      end
      if (data_end) begin
        data_reg <= byte_in;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Serial clock domain: status read out
  // --------------------------------------------------------------------------
  logic [3:0] sr_flags_s;
  logic       rd_oe_reg;
  logic [7:0] rd_shift_reg;

  bit_sync #(
    .WIDTH       (4),
    .RESET_VALUE (4'h0)
  ) u_sync_flags (
    .clk   (sck),
    .rst_b (rst_b),
    .d     ({protection_lock_bit, write_enable_latch, reset_command_enable, ready_busy_flag}),
    .q     (sr_flags_s)
  );

  wire flag_lock = sr_flags_s[3];
  wire flag_wel  = sr_flags_s[2];
  wire flag_reset_command_enable = sr_flags_s[1];
  wire flag_busy = sr_flags_s[0];

  logic [7:0] sr1_byte;
  logic [7:0] sr2_byte;

  always_comb begin
    sr1_byte                   = `FS_STATUS_ZERO;
    sr1_byte[`FS_SR1_LOCK_BIT] = flag_lock;
    sr1_byte[`FS_SR1_WEL_BIT]  = flag_wel;
    sr1_byte[`FS_SR_BUSY_BIT]  = flag_busy;
    sr2_byte                   = `FS_STATUS_ZERO;
    sr2_byte[`FS_SR2_RESET_COMMAND_ENABLE_BIT] = flag_reset_command_enable;
    sr2_byte[`FS_SR_BUSY_BIT]  = flag_busy;
  end

  wire flash_status_pkg::cmd_e link_cmd = decode_opcode(opcode_reg);
  wire rd_is_sr1 = (link_cmd == flash_status_pkg::CMD_READ_STATUS1);
  wire rd_is_sr2 = (link_cmd == flash_status_pkg::CMD_READ_STATUS2);
  wire rd_load   = frame_reg && (bit_cnt_reg == `FS_BIT_FIRST) && (bytes_reg != `FS_BYTES_NONE)
                   && (rd_is_sr1 || rd_is_sr2);

  // A fresh byte is loaded at every byte boundary, so a host that keeps
  // clocking sees the busy flag fall without restarting the command.
  always_ff @(negedge sck or posedge cs_b or negedge rst_b) begin
    if (!rst_b) begin
      rd_oe_reg    <= 1'h0;
      rd_shift_reg <= `FS_STATUS_ZERO;
    end else if (cs_b) begin
      rd_oe_reg    <= 1'h0;
      rd_shift_reg <= `FS_STATUS_ZERO;
    end else if (rd_load) begin
      rd_oe_reg    <= 1'h1;
      rd_shift_reg <= rd_is_sr2 ? sr2_byte : sr1_byte;
    end else begin
      rd_shift_reg <= {rd_shift_reg[6:0], 1'h0};
    end
  end

  // --------------------------------------------------------------------------
  // System domain: crossings
  // --------------------------------------------------------------------------
  logic cs_s;
  logic wp_s;
  logic op_tgl_s;
  logic cs_s_d_reg;
  logic op_tgl_d_reg;

  bit_sync #(
    .WIDTH       (2),
    .RESET_VALUE (2'h3)
  ) u_sync_pins (
    .clk   (sys_clk),
    .rst_b (rst_b),
    .d     ({cs_b, wp_b}),
    .q     ({cs_s, wp_s})
  );

  bit_sync #(
    .WIDTH       (1),
    .RESET_VALUE (1'h0)
  ) u_sync_op (
    .clk   (sys_clk),
    .rst_b (rst_b),
    .d     (op_tgl_reg),
    .q     (op_tgl_s)
  );

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_s_d_reg   <= 1'h1;
      op_tgl_d_reg <= 1'h0;
    end else begin
      cs_s_d_reg   <= cs_s;
      op_tgl_d_reg <= op_tgl_s;
    end
  end

  wire cs_rise = cs_s && !cs_s_d_reg;
  wire op_evt  = op_tgl_s ^ op_tgl_d_reg;

  // --------------------------------------------------------------------------
  // System domain: command tracking
  // --------------------------------------------------------------------------
  flash_status_pkg::link_state_e state_reg;
  flash_status_pkg::link_state_e state_next;
  flash_status_pkg::cmd_e        cmd_reg;

  wire flash_status_pkg::cmd_e cmd_now = op_evt ? link_cmd : cmd_reg;
  wire is_active = (cmd_now == flash_status_pkg::CMD_ACTIVE_STATUS);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      flash_status_pkg::LS_IDLE: begin
        if (op_evt && !cs_s) begin
          state_next = is_active ? flash_status_pkg::LS_ACTIVE : flash_status_pkg::LS_CMD;
        end
      end
      flash_status_pkg::LS_CMD: begin
        if (cs_s) begin
          state_next = flash_status_pkg::LS_IDLE;
        end
      end
      flash_status_pkg::LS_ACTIVE: begin
        if (cs_s) begin
          state_next = flash_status_pkg::LS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= flash_status_pkg::LS_IDLE;
      cmd_reg   <= flash_status_pkg::CMD_NONE;
    end else begin
      state_reg <= state_next;
      cmd_reg   <= cmd_now;
    end
  end

  // --------------------------------------------------------------------------
  // System domain: status writes
  // --------------------------------------------------------------------------
  // Counts and data are read only after chip select has risen, when the
  // serial clock is stopped and they cannot move.
  wire commit     = cs_rise && ((state_reg == flash_status_pkg::LS_CMD) || (state_reg == flash_status_pkg::LS_IDLE && op_evt));
  wire wr1_cmd    = commit && (cmd_now == flash_status_pkg::CMD_WRITE_STATUS1);
  wire wr2_cmd    = commit && (cmd_now == flash_status_pkg::CMD_WRITE_STATUS2);
  wire data_full  = (bytes_reg == `FS_BYTES_FULL);
  wire on_byte    = (bit_cnt_reg == `FS_BIT_FIRST);
  wire new_lock   = data_reg[`FS_WD_LOCK_BIT];
  wire wp_blocked = !wp_s && protection_lock_bit && !new_lock;
  wire wr1_ok     = wr1_cmd && write_enable_latch && data_full && !wp_blocked;
  wire wr2_ok     = wr2_cmd && write_enable_latch && data_full && on_byte;
  wire wel_drop   = wr1_cmd || wr2_cmd || wel_clear;

  logic wel_next;
  logic lock_next;
  logic reset_command_enable_next;

  assign wel_next  = wel_set ? 1'h1 : (wel_drop ? 1'h0 : write_enable_latch);
  assign lock_next = wr1_ok ? new_lock : protection_lock_bit;
  assign reset_command_enable_next = wr2_ok ? data_reg[`FS_WD_RESET_COMMAND_ENABLE_BIT] : reset_command_enable;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      write_enable_latch   <= `FS_WEL_RESET;
      protection_lock_bit  <= `FS_LOCK_RESET;
      reset_command_enable <= `FS_RESET_COMMAND_ENABLE_RESET;
    end else begin
      write_enable_latch   <= wel_next;
      protection_lock_bit  <= lock_next;
      reset_command_enable <= reset_command_enable_next;
    end
  end

  // The protect decision itself lies outside; it gets the code and the
  // lock value from before this write.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      global_protect_req        <= 1'h0;
      global_protect_code       <= 4'h0;
      global_protect_prior_lock <= 1'h0;
    end else begin
      global_protect_req <= wr1_ok;
      if (wr1_ok) begin
        global_protect_code       <= data_reg[`FS_WD_GP_MSB:`FS_WD_GP_LSB];
        global_protect_prior_lock <= protection_lock_bit;
      end
    end
  end

  // --------------------------------------------------------------------------
  // System domain: busy, reset gating and active status output
  // --------------------------------------------------------------------------
  logic asi_oe_reg;
  logic asi_so_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_busy_flag <= 1'h0;
      reset_accept    <= 1'h0;
      asi_oe_reg      <= 1'h0;
      asi_so_reg      <= 1'h0;
    end else begin
      ready_busy_flag <= op_busy;
      reset_accept    <= reset_cmd_req && reset_command_enable;
      asi_oe_reg      <= (state_next == flash_status_pkg::LS_ACTIVE);
      asi_so_reg      <= op_busy;
    end
  end

  always_comb begin
    status_byte2                   = `FS_STATUS_ZERO;
    status_byte2[`FS_SR2_RESET_COMMAND_ENABLE_BIT] = reset_command_enable;
    status_byte2[`FS_SR_BUSY_BIT]  = ready_busy_flag;
  end

  // Both drivers are released by chip select, so the two never overlap.
  assign so_out = asi_oe_reg ? asi_so_reg : rd_shift_reg[7];
  assign so_oe  = asi_oe_reg || rd_oe_reg;

endmodule : flash_status_register_commands

// ### tb/flash_status_register_commands_properties.sv
// Concurrent checks on the ports of the status register command block.
`timescale 1ns/1ns
module flash_status_register_commands_properties (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       cs_b,
  input wire logic       so_out,
  input wire logic       so_oe,
  input wire logic       wp_b,
  input wire logic       op_busy,
  input wire logic       wel_set,
  input wire logic       reset_cmd_req,
  input wire logic       reset_accept,
  input wire logic       write_enable_latch,
  input wire logic       protection_lock_bit,
  input wire logic       reset_command_enable,
  input wire logic       ready_busy_flag,
  input wire logic [7:0] status_byte2,
  input wire logic       global_protect_req,
  input wire logic       global_protect_prior_lock
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_byte2_layout: assert property (status_byte2 == {3'h0, reset_command_enable, 3'h0, ready_busy_flag})
    else $error("second status byte layout wrong");
  a_busy_follow: assert property (1'h1 |=> ready_busy_flag == $past(op_busy))
    else $error("busy flag does not track the operation");
  a_reset_accept: assert property (reset_cmd_req && reset_command_enable |=> reset_accept)
    else $error("enabled reset command not accepted");
  a_reset_ignore: assert property (!(reset_cmd_req && reset_command_enable) |=> !reset_accept)
    else $error("reset accepted while disabled");
  a_reset_command_enable_write: assert property ($changed(reset_command_enable) |-> $past(write_enable_latch) && !write_enable_latch && cs_b)
    else $error("reset enable changed outside a status write");
  a_lock_write: assert property ($changed(protection_lock_bit) |-> $past(write_enable_latch) && !write_enable_latch && cs_b)
    else $error("lock changed outside a status write");
  a_wp_hold: assert property ($fell(protection_lock_bit) |-> $past(wp_b, 2) || $past(wp_b, 3) || $past(wp_b, 4) || $past(wp_b, 5))
    else $error("lock cleared while write protect asserted");
  a_protect_req: assert property (global_protect_req |-> !write_enable_latch && global_protect_prior_lock == $past(protection_lock_bit) ##1 !global_protect_req)
    else $error("protect request malformed");
  a_so_release: assert property (cs_b [*5] |-> !so_oe)
    else $error("serial output still driven after deselect");
  a_wel_set: assert property (wel_set |=> write_enable_latch)
    else $error("write enable latch not set");

  c_protect: cover property (global_protect_req);
  c_accept: cover property (reset_accept);
  c_active: cover property (so_oe && so_out && !cs_b ##1 !so_out);
endmodule : flash_status_register_commands_properties

// ### tb/spi_host_model.sv
// Behavioural SPI host in mode 0 that frames commands and collects the serial output.
`timescale 1ns/1ns
module spi_host_model (
  output logic      sck,
  output logic      cs_b,
  output logic      si,
  input wire logic  so_out,
  input wire logic  so_oe
);
  initial begin
    sck = 1'h0;
    cs_b = 1'h1;
    si = 1'h0;
  end

  // The clock stands low outside frames; a released data line shows the inverse of its last bit.
  task automatic xfer(input logic [23:0] word, input int nbits, input bit hold, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    cs_b = 1'h0;
    #40;
    for (i = 0; i < nbits; i++) begin
      si = word[23-i];
      #40;
      sck = 1'h1;
      rx = {rx[6:0], so_oe ? so_out : 1'bz};
      #40;
      sck = 1'h0;
    end
    si = ~si;
    #400;
    if (!hold) cs_b = 1'h1;
  endtask : xfer

  task automatic deselect();
    cs_b = 1'h1;
  endtask : deselect
endmodule : spi_host_model

// ### tb/test_flash_status_register_commands.sv
// Self-checking bench for the status register command block.
`timescale 1ns/1ns
module test_flash_status_register_commands;
  logic       sys_clk, rst_b, sck, cs_b, si, so_out, so_oe, wp_b, op_busy;
  logic       wel_set, wel_clear, reset_cmd_req, reset_accept, write_enable_latch;
  logic       protection_lock_bit, reset_command_enable, ready_busy_flag;
  logic [7:0] status_byte2, rx;
  logic       global_protect_req, global_protect_prior_lock;
  logic [3:0] global_protect_code;
  logic [35:0] c;
  int         mismatches, n_checks, cycles, n_req, i;

  // Fields: expected, write enable first, protect pin, opcode, data, bit count.
  localparam logic [35:0] CASES [11] = '{36'h111311010, 36'h11131EF0C, 36'h11131EF14, 36'h01131EF10,
    36'h111311018, 36'h001018010, 36'h11101BC10, 36'h11101000C, 36'h110010010, 36'h110018010, 36'h011017F18};

  flash_status_register_commands dut (.sys_clk(sys_clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si),
    .so_out(so_out), .so_oe(so_oe), .wp_b(wp_b), .op_busy(op_busy), .wel_set(wel_set), .wel_clear(wel_clear),
    .reset_cmd_req(reset_cmd_req), .reset_accept(reset_accept), .write_enable_latch(write_enable_latch),
    .protection_lock_bit(protection_lock_bit), .reset_command_enable(reset_command_enable),
    .ready_busy_flag(ready_busy_flag), .status_byte2(status_byte2), .global_protect_req(global_protect_req),
    .global_protect_code(global_protect_code), .global_protect_prior_lock(global_protect_prior_lock));

  spi_host_model host (.sck(sck), .cs_b(cs_b), .si(si), .so_out(so_out), .so_oe(so_oe));

  initial sys_clk = 1'h0;
  always #50 sys_clk = ~sys_clk;

  // Runs far longer than all tests need, so only a hang reaches it.
  always @(posedge sys_clk) begin
    cycles++;
    if (global_protect_req === 1'h1) n_req++;
    if (cycles == 6000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      mismatches++;
    end
  endtask : chk

  task automatic wait_sys(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_sys

  task automatic pulse_reset(input logic exp);
    @(posedge sys_clk);
    reset_cmd_req <= 1'h1;
    @(posedge sys_clk);
    reset_cmd_req <= 1'h0;
    #1;
    chk({7'h00, reset_accept}, {7'h00, exp});
  endtask : pulse_reset

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  initial begin
    {rst_b, wel_set, wel_clear, reset_cmd_req, op_busy} = 5'h00;
    wp_b = 1'h1;
    wait_sys(6);
    rst_b <= 1'h1;
    wait_sys(4);
    chk({5'h00, write_enable_latch, protection_lock_bit, reset_command_enable}, 8'h00);
    chk(status_byte2, 8'h00);
    pulse_reset(1'h0);
    wel_set <= 1'h1;
    @(posedge sys_clk);
    {wel_set, wel_clear} <= 2'h1;
    @(posedge sys_clk);
    wel_clear <= 1'h0;
    wait_sys(1);
    chk({7'h00, write_enable_latch}, 8'h00);
    $display("reset test done");
    for (i = 0; i < 11; i++) begin
      c = CASES[i];
      @(posedge sys_clk);
      wp_b <= c[24];
      wel_set <= c[28];
      @(posedge sys_clk);
      wel_set <= 1'h0;
      wait_sys(4);
      host.xfer({c[23:8], 8'hA5}, int'(c[7:0]), 1'b0, rx);
      wait_sys(8);
      chk({7'h00, write_enable_latch}, 8'h00);
      chk({7'h00, c[23:16] == 8'h31 ? reset_command_enable : protection_lock_bit}, {7'h00, c[32]});
    end
    chk({4'h0, global_protect_code}, 8'h0F);
    chk({7'h00, global_protect_prior_lock}, 8'h01);
    chk(n_req[7:0], 8'h03);
    $display("status write test done");
    pulse_reset(1'h1);
    chk({7'h00, reset_command_enable}, 8'h01);
    $display("reset gate test done");
    @(posedge sys_clk);
    op_busy <= 1'h1;
    wait_sys(2);
    chk(status_byte2, 8'h11);
    host.xfer({8'h35, 16'h0000}, 16, 1'b0, rx);
    chk(rx, 8'h11);
    wait_sys(6);
    host.xfer({8'h05, 16'h0000}, 16, 1'b0, rx);
    chk(rx, 8'h01);
    wait_sys(6);
    $display("status read test done");
    host.xfer({8'h25, 16'h0000}, 8, 1'b1, rx);
    wait_sys(3);
    chk({6'h00, so_oe, so_out}, 8'h03);
    @(posedge sys_clk);
    op_busy <= 1'h0;
    wait_sys(3);
    chk({6'h00, so_oe, so_out}, 8'h02);
    host.deselect();
    wait_sys(6);
    chk({7'h00, so_oe}, 8'h00);
    host.xfer({8'h35, 16'h0000}, 16, 1'b0, rx);
    chk(rx, 8'h10);
    $display("active status test done");
    stop_test();
  end
endmodule : test_flash_status_register_commands

bind flash_status_register_commands flash_status_register_commands_properties u_props (.sys_clk(sys_clk),
  .rst_b(rst_b), .cs_b(cs_b), .so_out(so_out), .so_oe(so_oe), .wp_b(wp_b), .op_busy(op_busy),
  .wel_set(wel_set), .reset_cmd_req(reset_cmd_req), .reset_accept(reset_accept),
  .write_enable_latch(write_enable_latch), .protection_lock_bit(protection_lock_bit),
  .reset_command_enable(reset_command_enable), .ready_busy_flag(ready_busy_flag),
  .status_byte2(status_byte2), .global_protect_req(global_protect_req),
  .global_protect_prior_lock(global_protect_prior_lock));
